/* srfc_pkg.sv */
// constants, types and register map of the rts/cts flow control block
//
// Function
// - six flow modes, numbered zero to five
// - reset mode zero: auto rts, ignore cts
// - rts command in mode zero selects manual
// - mode one: cts ignored, rts by user
// - mode two: send on cts, rts by user
// - mode three: auto rts plus extension time
// - modes three/four: user rts holds line on
// - user drop waits for drain and extension
// - mode four: raise rts, await cts, drop after
// - mode five: rts on while receive has room
// - mode five: rts low until receive level falls to the low threshold
// - default bit rate 153.3 kbps
package srfc_pkg;

  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int BIT_RATE_BPS = 153_300;
  localparam int BIT_DIV = CLK_HZ / BIT_RATE_BPS;

  // data path
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [2:0] LAST_BIT = 3'h7;

  // register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RTS_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TXDATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_EXT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_BITDIV = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RXTHR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

  // field positions
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam int RTS_CMD_BIT = 0;
  localparam int THR_HIGH_LSB = 0;
  localparam int THR_HIGH_MSB = 7;
  localparam int THR_LOW_LSB = 8;
  localparam int THR_LOW_MSB = 15;
  localparam int ST_AUTO = 0;
  localparam int ST_RTS = 1;
  localparam int ST_CTS = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_LVL_LSB = 4;
  localparam int ST_LVL_MSB = 7;
  localparam int ST_RXOK = 8;
  localparam int ST_MODE_LSB = 12;
  localparam int ST_MODE_MSB = 14;

  typedef enum logic [2:0] {
    MODE_NONE = 3'b000,
    MODE_MANUAL = 3'b001,
    MODE_AUTO_CTS = 3'b010,
    MODE_AUTO_RTS = 3'b011,
    MODE_FULL_AUTO = 3'b100,
    MODE_DYNAMIC = 3'b101
  } srfc_mode_e;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_DATA = 2'b01,
    TX_STOP = 2'b10
  } srfc_tx_e;

  typedef struct packed {
    srfc_mode_e mode;
    logic [15:0] extBits;
    logic [15:0] bitDiv;
    logic [7:0] rxHigh;
    logic [7:0] rxLow;
  } srfc_cfg_s;

  // reset values
  localparam srfc_mode_e MODE_RST = MODE_NONE;
  localparam logic [15:0] EXT_RST = 16'h0000;
  localparam logic [15:0] BITDIV_RST = 16'(BIT_DIV);
  localparam logic [7:0] RX_HIGH_RST = 8'hE0;
  localparam logic [7:0] RX_LOW_RST = 8'h80;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage

/* srfc_fifo.sv */
// parameterised fifo that buffers transmit characters
`timescale 1ns/1ns
`default_nettype none
module srfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  assign inReady = (count != CW'(DEPTH));
  assign outValid = (count != '0);
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = mem[rdPtr];
  assign level = count;

  ////////////////////////////////////////////////////////////////////////
  // storage has no reset: contents are only read behind a valid count
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + AW'(1);
      end
      if (pop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + AW'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + CW'(1);
    end else if (pop && !push) begin
      count <= count - CW'(1);
    end
  end

endmodule // srfc_fifo
`default_nettype wire

/* srfc_top.sv */
// rts/cts flow control with apb registers and a character transmitter
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module srfc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [srfc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ctsIn,
  input wire logic [7:0] rxLevel,
  output logic txd,
  output logic rtsOut
);

  srfc_pkg::srfc_cfg_s cfg;
  srfc_pkg::srfc_tx_e txState;
  logic userRts;
  logic ctsMeta;
  logic ctsSync;
  logic rxOk;
  logic autoHold;
  logic extRun;
  logic [15:0] extCnt;
  logic [15:0] bitCnt;
  logic bitTick;
  logic [srfc_pkg::DATA_W-1:0] shifter;
  logic [2:0] bitIdx;
  logic next_rts;
  logic mapped;
  logic access;
  logic wrEn;
  logic txPush;
  logic fifoInReady;
  logic fifoValid;
  logic fifoPop;
  logic [srfc_pkg::DATA_W-1:0] fifoData;
  logic [srfc_pkg::FIFO_CNT_W-1:0] fifoLevel;
  logic txBusy;
  logic drained;
  logic ctsNeeded;
  logic txGo;
  logic autoMode;
  logic [31:0] readVal;

  ////////////////////////////////////////////////////////////////////////
  // apb slave

  assign access = psel & penable;

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      srfc_pkg::OFS_CTRL: mapped = 1'b1;
      srfc_pkg::OFS_RTS_CMD: mapped = 1'b1;
      srfc_pkg::OFS_TXDATA: mapped = 1'b1;
      srfc_pkg::OFS_EXT: mapped = 1'b1;
      srfc_pkg::OFS_BITDIV: mapped = 1'b1;
      srfc_pkg::OFS_RXTHR: mapped = 1'b1;
      srfc_pkg::OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // a character write waits while the fifo is full: back-pressure to cpu
  assign pready = !(psel && pwrite && (paddr == srfc_pkg::OFS_TXDATA) &&
                    !fifoInReady);
  assign pslverr = access & !mapped;
  assign wrEn = access & pwrite & pready & mapped;
  assign txPush = access & pwrite & (paddr == srfc_pkg::OFS_TXDATA);

  always_comb begin
    readVal = srfc_pkg::READ_ZERO;
    case (paddr)
      srfc_pkg::OFS_CTRL:
        readVal[srfc_pkg::MODE_MSB:srfc_pkg::MODE_LSB] = cfg.mode;
      srfc_pkg::OFS_RTS_CMD:
        readVal[srfc_pkg::RTS_CMD_BIT] = userRts;
      srfc_pkg::OFS_EXT:
        readVal[15:0] = cfg.extBits;
      srfc_pkg::OFS_BITDIV:
        readVal[15:0] = cfg.bitDiv;
      srfc_pkg::OFS_RXTHR: begin
        readVal[srfc_pkg::THR_HIGH_MSB:srfc_pkg::THR_HIGH_LSB] = cfg.rxHigh;
        readVal[srfc_pkg::THR_LOW_MSB:srfc_pkg::THR_LOW_LSB] = cfg.rxLow;
      end
      srfc_pkg::OFS_STATUS: begin
        readVal[srfc_pkg::ST_AUTO] = autoHold;
        readVal[srfc_pkg::ST_RTS] = rtsOut;
        readVal[srfc_pkg::ST_CTS] = ctsSync;
        readVal[srfc_pkg::ST_BUSY] = txBusy;
        readVal[srfc_pkg::ST_LVL_MSB:srfc_pkg::ST_LVL_LSB] = fifoLevel;
        readVal[srfc_pkg::ST_RXOK] = rxOk;
        readVal[srfc_pkg::ST_MODE_MSB:srfc_pkg::ST_MODE_LSB] = cfg.mode;
      end
      default: readVal = srfc_pkg::READ_ZERO;
    endcase
  end

  // read data is caught in the setup cycle so that it leaves a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= srfc_pkg::READ_ZERO;
    end else if (psel && !penable && !pwrite) begin
      prdata <= readVal;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg.mode <= srfc_pkg::MODE_RST;
    end else if (wrEn && paddr == srfc_pkg::OFS_CTRL) begin
      // codes above five are not modes and leave the mode alone
      if (pwdata[srfc_pkg::MODE_MSB:srfc_pkg::MODE_LSB] <=
          srfc_pkg::MODE_DYNAMIC) begin
        cfg.mode <= srfc_pkg::srfc_mode_e'(
          pwdata[srfc_pkg::MODE_MSB:srfc_pkg::MODE_LSB]);
      end
    end else if (wrEn && paddr == srfc_pkg::OFS_RTS_CMD &&
                 cfg.mode == srfc_pkg::MODE_NONE) begin
      cfg.mode <= srfc_pkg::MODE_MANUAL;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg.extBits <= srfc_pkg::EXT_RST;
      cfg.bitDiv <= srfc_pkg::BITDIV_RST;
      cfg.rxHigh <= srfc_pkg::RX_HIGH_RST;
      cfg.rxLow <= srfc_pkg::RX_LOW_RST;
    end else if (wrEn) begin
      case (paddr)
        srfc_pkg::OFS_EXT: cfg.extBits <= pwdata[15:0];
        srfc_pkg::OFS_BITDIV: cfg.bitDiv <= pwdata[15:0];
        srfc_pkg::OFS_RXTHR: begin
          cfg.rxHigh <= pwdata[srfc_pkg::THR_HIGH_MSB:srfc_pkg::THR_HIGH_LSB];
          cfg.rxLow <= pwdata[srfc_pkg::THR_LOW_MSB:srfc_pkg::THR_LOW_LSB];
        end
        default: cfg.extBits <= cfg.extBits;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      userRts <= 1'b0;
    end else if (wrEn && paddr == srfc_pkg::OFS_RTS_CMD) begin
      userRts <= pwdata[srfc_pkg::RTS_CMD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cts synchroniser and receive-room hysteresis

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctsMeta <= 1'b0;
      ctsSync <= 1'b0;
    end else begin
      ctsMeta <= ctsIn;
      ctsSync <= ctsMeta;
    end
  end

  // between the two levels the last decision stands, so rts stays calm
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxOk <= 1'b1;
    end else if (rxLevel >= cfg.rxHigh) begin
      rxOk <= 1'b0;
    end else if (rxLevel <= cfg.rxLow) begin
      rxOk <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit-period divider; a zero divider is treated as one

  assign bitTick = ((bitCnt + 16'h0001) >= cfg.bitDiv);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bitCnt <= '0;
    end else if (bitTick) begin
      bitCnt <= '0;
    end else begin
      bitCnt <= bitCnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit buffer and transmitter

  srfc_fifo #(
    .WIDTH(srfc_pkg::DATA_W),
    .DEPTH(srfc_pkg::FIFO_DEPTH)
  ) txFifo (
    .clk(clk),
    .rst(rst),
    .inValid(txPush),
    .inReady(fifoInReady),
    .inData(pwdata[srfc_pkg::DATA_W-1:0]),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData),
    .level(fifoLevel)
  );

  assign txBusy = (txState != srfc_pkg::TX_IDLE);
  assign drained = !fifoValid && !txBusy;
  assign ctsNeeded = (cfg.mode == srfc_pkg::MODE_AUTO_CTS) ||
                     (cfg.mode == srfc_pkg::MODE_FULL_AUTO) ||
                     (cfg.mode == srfc_pkg::MODE_DYNAMIC);
  // cts only gates the start of a character, never one in flight
  assign txGo = !ctsNeeded || ctsSync;
  assign fifoPop = bitTick && (txState == srfc_pkg::TX_IDLE) && txGo;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txState <= srfc_pkg::TX_IDLE;
      txd <= 1'b1;
      shifter <= '0;
      bitIdx <= '0;
    end else if (bitTick) begin
      case (txState)
        srfc_pkg::TX_IDLE: begin
          if (fifoValid && txGo) begin
            txd <= 1'b0;
            shifter <= fifoData;
            bitIdx <= '0;
            txState <= srfc_pkg::TX_DATA;
          end
        end
        srfc_pkg::TX_DATA: begin
          txd <= shifter[0];
          shifter <= shifter >> 1;
          if (bitIdx == srfc_pkg::LAST_BIT) begin
            txState <= srfc_pkg::TX_STOP;
          end else begin
            bitIdx <= bitIdx + 3'h1;
          end
        end
        srfc_pkg::TX_STOP: begin
          txd <= 1'b1;
          txState <= srfc_pkg::TX_IDLE;
        end
        default: txState <= srfc_pkg::TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // automatic rts hold with extension

  assign autoMode = (cfg.mode == srfc_pkg::MODE_NONE) ||
                    (cfg.mode == srfc_pkg::MODE_AUTO_RTS) ||
                    (cfg.mode == srfc_pkg::MODE_FULL_AUTO);

  // a new character wins over a drop in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      autoHold <= 1'b0;
      extRun <= 1'b0;
      extCnt <= '0;
    end else if (!autoMode) begin
      autoHold <= 1'b0;
      extRun <= 1'b0;
    end else if (txPush) begin
      autoHold <= 1'b1;
      extRun <= 1'b0;
    end else if (autoHold && drained && !extRun) begin
      if (cfg.mode == srfc_pkg::MODE_NONE || cfg.extBits == '0) begin
        autoHold <= 1'b0;
      end else begin
        extRun <= 1'b1;
        extCnt <= cfg.extBits;
      end
    end else if (extRun && bitTick) begin
      if (extCnt == 16'h0001) begin
        extRun <= 1'b0;
        autoHold <= 1'b0;
      end else begin
        extCnt <= extCnt - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rts line

  always_comb begin
    case (cfg.mode)
      srfc_pkg::MODE_NONE: next_rts = autoHold;
      srfc_pkg::MODE_MANUAL: next_rts = userRts;
      srfc_pkg::MODE_AUTO_CTS: next_rts = userRts;
      // the user level keeps the line on; auto hold covers the drain
      srfc_pkg::MODE_AUTO_RTS: next_rts = userRts | autoHold;
      srfc_pkg::MODE_FULL_AUTO: next_rts = userRts | autoHold;
      srfc_pkg::MODE_DYNAMIC: next_rts = rxOk;
      default: next_rts = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rtsOut <= 1'b0;
    end else begin
      rtsOut <= next_rts;
    end
  end

endmodule // srfc_top
`default_nettype wire

/* srfc_checker_assertions.sv */
// port-level assertions for the rts/cts flow control block
`timescale 1ns/1ns
`default_nettype none
module srfc_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [srfc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ctsIn,
  input wire logic [7:0] rxLevel,
  input wire logic txd,
  input wire logic rtsOut
);
  logic [2:0] mode;
  logic usr;
  logic wr;
  logic [10:0] lowCnt;
  logic [7:0] thrHigh;
  logic [7:0] thrLow;
  assign wr = psel && penable && pwrite && pready;
  // mirrors of mode, user rts and thresholds, so no internal probes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode <= 3'h0;
    end else if (wr && paddr == 8'h00 && pwdata[2:0] <= 3'h5) begin
      mode <= pwdata[2:0];
    end else if (wr && paddr == 8'h04 && mode == 3'h0) begin
      mode <= 3'h1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      usr <= 1'b0;
    end else if (wr && paddr == 8'h04) begin
      usr <= pwdata[0];
    end
  end
  // thresholds are programmable, so the checker follows every write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thrHigh <= srfc_pkg::RX_HIGH_RST;
      thrLow <= srfc_pkg::RX_LOW_RST;
    end else if (wr && paddr == 8'h14) begin
      thrHigh <= pwdata[7:0];
      thrLow <= pwdata[15:8];
    end
  end
  // longer than a frame at the reset divider, so bits of a frame in flight never count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lowCnt <= 11'h000;
    end else if (ctsIn || mode == 3'h0 || mode == 3'h1 || mode == 3'h3) begin
      lowCnt <= 11'h000;
    end else if (lowCnt != 11'h7FF) begin
      lowCnt <= lowCnt + 11'h001;
    end
  end
  //////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_auto_push;
    wr && paddr == 8'h08 && (mode == 3'h0 || mode == 3'h3 || mode == 3'h4);
  endsequence
  sequence s_user_cmd;
    wr && paddr == 8'h04 && mode <= 3'h2;
  endsequence
  a_auto_rise: assert property (
      s_auto_push |-> ##2 rtsOut)
    else $error("rts not raised after a push");
  a_user_rts: assert property (
      s_user_cmd |-> ##2 rtsOut == $past(pwdata[0], 2))
    else $error("rts does not follow the user command");
  a_user_quiet: assert property (
      ((mode == 3'h1 || mode == 3'h2) && !(wr && paddr == 8'h04))[*3]
      |=> $stable(rtsOut))
    else $error("rts moved without a user command");
  a_user_hold: assert property (
      ((mode == 3'h3 || mode == 3'h4) && usr)[*2] |=> rtsOut)
    else $error("rts dropped while user holds it");
  a_cts_gate: assert property (
      lowCnt >= 11'h3E8 |-> !$fell(txd))
    else $error("character started without cts");
  a_dyn_drop: assert property (
      (mode == 3'h5 && rxLevel >= thrHigh)[*2] |=> !rtsOut)
    else $error("rts high with receive buffer near full");
  a_dyn_raise: assert property (
      (mode == 3'h5 && rxLevel <= thrLow)[*2] |=> rtsOut)
    else $error("rts low with receive room");
  a_ready_free: assert property (
      psel && !(pwrite && paddr == 8'h08) |-> pready)
    else $error("wait state on a plain access");
endmodule // srfc_checker
`default_nettype wire

/* srfc_far_end.sv */
// far-end terminal model: grants cts and receives 8n1 characters
`timescale 1ns/1ns
`default_nettype none
module srfc_far_end #(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic txd,
  input wire logic rtsOut,
  input wire logic ctsAllow,
  input wire logic follow,
  output logic ctsIn,
  output logic [7:0] byteCount,
  output logic [7:0] lastByte
);
  logic [7:0] sh;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctsIn <= 1'b0;
    end else begin
      ctsIn <= ctsAllow && (!follow || rtsOut);
    end
  end
  initial byteCount = 8'h00;
  // samples mid-bit on the falling clock to stay clear of txd updates
  always begin
    @(negedge txd);
    if (!rst) begin
      repeat (DIV + DIV / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        sh[i] = txd;
        repeat (DIV) @(negedge clk);
      end
      if (txd === 1'b1) begin
        lastByte = sh;
        byteCount = byteCount + 8'h01;
      end
    end
  end
endmodule // srfc_far_end
`default_nettype wire

/* srfc_testbench.sv */
// self-checking testbench for the rts/cts flow control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic ctsIn, txd, rtsOut, ctsAllow, follow, er;
  logic [7:0] paddr, rxLevel, byteCount, lastByte;
  logic [31:0] pwdata, prdata, rd;
  int fail_count, total_checks, w;
  srfc_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ctsIn(ctsIn), .rxLevel(rxLevel),
    .txd(txd), .rtsOut(rtsOut));
  srfc_far_end #(.DIV(4)) u_far (.clk(clk), .rst(rst), .txd(txd),
    .rtsOut(rtsOut), .ctsAllow(ctsAllow), .follow(follow), .ctsIn(ctsIn),
    .byteCount(byteCount), .lastByte(lastByte));
  //////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic wrt, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wrt;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    w = 0;
    while (pready !== 1'b1) begin
      @(posedge clk);
      w++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task waitRts(input logic v);
    for (int n = 0; n < 3000 && rtsOut !== v; n++) @(posedge clk);
    chk(rtsOut, v);
  endtask
  task waitBytes(input logic [7:0] c);
    for (int n = 0; n < 3000 && byteCount !== c; n++) @(posedge clk);
    chk(byteCount, c);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(20_000 * 100);
    fail_count++;
    test_done;
  end
  initial begin
    {rst, psel, penable, pwrite, ctsAllow, follow} = 6'h20;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rxLevel = 8'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(0, 8'h18, 0);
    chk(rd, 32'h0000_0100);
    apb(0, 8'h10, 0);
    chk(rd, srfc_pkg::BITDIV_RST);
    apb(1, 8'h10, 4);
    apb(1, 8'h08, 8'h55);
    waitRts(1);
    waitBytes(1);
    chk(lastByte, 8'h55);
    waitRts(0);
    apb(0, 8'h1C, 0);
    chk(er, 1);
    chk(rd, 0);
    apb(1, 8'h04, 1);
    apb(0, 8'h18, 0);
    chk(rd[14:12], 1);
    apb(1, 8'h08, 8'hA3);
    waitBytes(2);
    chk(lastByte, 8'hA3);
    chk(rtsOut, 1);
    apb(1, 8'h04, 0);
    apb(1, 8'h00, 2);
    // ninth push must stall until the stalled far end grants cts
    for (int i = 0; i < 8; i++) apb(1, 8'h08, i);
    fork
      apb(1, 8'h08, 8);
      begin
        repeat (1100) @(posedge clk);
        chk({byteCount, pready}, 9'h004);
        ctsAllow <= 1'b1;
      end
    join
    chk(w > 1000, 1);
    waitBytes(11);
    chk(lastByte, 8);
    apb(0, 8'h18, 0);
    chk(rd[7:4], 0);
    ctsAllow <= 1'b0;
    apb(1, 8'h0C, 3);
    apb(0, 8'h0C, 0);
    chk(rd, 3);
    apb(1, 8'h00, 3);
    apb(1, 8'h08, 8'h3C);
    waitRts(1);
    waitBytes(12);
    repeat (8) @(posedge clk);
    chk(rtsOut, 1);
    waitRts(0);
    apb(1, 8'h04, 1);
    apb(1, 8'h08, 8'h77);
    waitBytes(13);
    repeat (40) @(posedge clk);
    chk(rtsOut, 1);
    apb(1, 8'h08, 8'h11);
    apb(1, 8'h08, 8'h22);
    apb(1, 8'h04, 0);
    waitBytes(15);
    chk(rtsOut, 1);
    waitRts(0);
    follow <= 1'b1;
    ctsAllow <= 1'b1;
    apb(1, 8'h00, 4);
    apb(1, 8'h08, 8'hC5);
    waitRts(1);
    waitBytes(16);
    chk(lastByte, 8'hC5);
    waitRts(0);
    apb(1, 8'h00, 5);
    rxLevel <= 8'hF0;
    repeat (3) @(posedge clk);
    chk(rtsOut, 0);
    rxLevel <= 8'hA0;
    repeat (3) @(posedge clk);
    chk(rtsOut, 0);
    rxLevel <= 8'h80;
    repeat (3) @(posedge clk);
    chk(rtsOut, 1);
    // raised thresholds: a level that would drop rts by default holds it
    apb(1, 8'h14, 32'h0000_90F0);
    apb(0, 8'h14, 0);
    chk(rd, 32'h0000_90F0);
    rxLevel <= 8'hE8;
    repeat (3) @(posedge clk);
    chk(rtsOut, 1);
    apb(1, 8'h00, 7);
    apb(0, 8'h18, 0);
    chk(rd[14:12], 5);
    test_done;
  end
endmodule // testbench
bind srfc_top srfc_checker u_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctsIn(ctsIn),
  .rxLevel(rxLevel), .txd(txd), .rtsOut(rtsOut));
`default_nettype wire
